// [hdl/msrc_cfg.svh]
`ifndef MSRC_CFG_SVH
`define MSRC_CFG_SVH
// register byte addresses
`define MSRC_OFS_SYSCTL    12'h000
`define MSRC_OFS_STBY1     12'h004
`define MSRC_OFS_STBY2     12'h008
// reset values
`define MSRC_RST_SYSCTL    8'hC1
`define MSRC_RST_STBY1     16'hF03F
`define MSRC_RST_STBY2     16'hF0F0
// writable bit masks
`define MSRC_WM_SYSCTL     8'h03
`define MSRC_WM_STBY1      16'h0F1C
`define MSRC_WM_STBY2      16'h727D
// bits forced to one on read
`define MSRC_ONE_SYSCTL    8'hC0
`define MSRC_ONE_STBY1     16'hF023
`define MSRC_ONE_STBY2     16'h8080
// system control fields
`define MSRC_BIT_RAM_EN    0
`define MSRC_BIT_TRC_RSTN  1
// first standby fields
`define MSRC_BIT_S_RAM     11
`define MSRC_BIT_S_ROM     10
`define MSRC_BIT_S_XFER_HI 9
`define MSRC_BIT_S_XFER_LO 8
`define MSRC_BIT_S_SER4    4
`define MSRC_BIT_S_SER3    3
`define MSRC_BIT_S_SER2    2
// second standby fields
`define MSRC_BIT_S_MOTOR   14
`define MSRC_BIT_S_PULSE   13
`define MSRC_BIT_S_CMPT    12
`define MSRC_BIT_S_CAN     9
`define MSRC_BIT_S_CONV2   6
`define MSRC_BIT_S_CONV1   5
`define MSRC_BIT_S_CONV0   4
`define MSRC_BIT_S_TRACE   3
`define MSRC_BIT_S_BOUND   2
`define MSRC_BIT_S_BREAK   0
`endif

// [hdl/msrc_pkg.sv]
package msrc_pkg;
    // register selector
    typedef enum logic [2:0] {
        MSRC_SEL_NONE = 3'h0,
        MSRC_SEL_SYS  = 3'h1,
        MSRC_SEL_ST1  = 3'h2,
        MSRC_SEL_ST2  = 3'h4
    } msrc_sel_t;
    // apb slave phase
    typedef enum logic [1:0] {
        MSRC_ST_IDLE = 2'h1,
        MSRC_ST_ACC  = 2'h2
    } msrc_state_t;
endpackage

// [hdl/msrc_decode.sv]
`timescale 1ns/10ps
`include "msrc_cfg.svh"
// address decode to one-hot register selector
module msrc_decode (
    // bus address
    input  wire logic [11:0]         paddr,
    // selector out
    output msrc_pkg::msrc_sel_t      sel
);
    // match each word address
    always_comb begin
        case (paddr)
            `MSRC_OFS_SYSCTL: sel = msrc_pkg::MSRC_SEL_SYS;
            `MSRC_OFS_STBY1:  sel = msrc_pkg::MSRC_SEL_ST1;
            `MSRC_OFS_STBY2:  sel = msrc_pkg::MSRC_SEL_ST2;
            default:          sel = msrc_pkg::MSRC_SEL_NONE;
        endcase
    end
endmodule // msrc_decode

// [hdl/msrc_ram_gate.sv]
`timescale 1ns/10ps
// gates on-chip ram access by the enable level
module msrc_ram_gate (
    // enable level
    input  wire logic        ram_en,
    // cpu side
    input  wire logic        cpu_ram_we,
    input  wire logic [31:0] ram_rdata,
    // ram side and cpu return
    output logic             ram_we,
    output logic [31:0]      cpu_ram_rdata
);
    // RL3 block when disabled
    // writes dropped, reads return a fixed filler
    always_comb begin
        ram_we        = cpu_ram_we & ram_en;
        cpu_ram_rdata = ram_en ? ram_rdata : 32'hFFFFFFFF;
    end
endmodule // msrc_ram_gate

// [hdl/msrc_top.sv]
`timescale 1ns/10ps
`include "msrc_cfg.svh"
// How it works
// RL1 - a zero in system control bit 1 holds the trace debugger in reset.
// RL2 - system control bit 0 enables on-chip ram and resets to one.
// RL3 - with ram disabled, reads give filler data and writes are dropped.
// RL4 - software puts no ram access right after a write clearing enable.
// RL5 - software reads system control after setting enable before ram use.
// RL6 - system control is 8 bits, bits 1 and 0 writable, bits 7 and 6 read-only and read as one.
// RL7 - a one in a standby bit puts its module in standby, zero releases.
// RL8 - software writes the two transfer controller bits with equal values.
// RL9 - first standby maps ram, rom, transfer and serial four to two bits.
// RL10 - first standby bits 15 to 12 and 1 to 0 read as ones.
// RL11 - second standby timer and converter bits reset to one.
// RL12 - second standby can and debug bits reset to zero.
// RL13 - single reserved bits 5, 15 and 7 stay at one.
// RL14 - read-only reserved fields read as zeros.
// RL15 - second standby bits 11, 10, 8 and 1 read as zero.
// RL16 - software clears ram enable before hardware standby entry.
// RL17 - each control output is a flop that changes at the write edge.
module msrc_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // ram access path
    input  wire logic        cpu_ram_we,
    input  wire logic [31:0] ram_rdata,
    output logic             ram_we,
    output logic [31:0]      cpu_ram_rdata,
    // module controls
    output logic             internal_ram_enable,
    output logic             trace_debugger_soft_reset_n,
    output logic             stop_internal_ram,
    output logic             stop_internal_rom,
    output logic             stop_transfer_ctrl_hi,
    output logic             stop_transfer_ctrl_lo,
    output logic             stop_serial_four,
    output logic             stop_serial_three,
    output logic             stop_serial_two,
    output logic             stop_motor_timer,
    output logic             stop_pulse_timer,
    output logic             stop_compare_timer,
    output logic             stop_can_controller,
    output logic             stop_converter_two,
    output logic             stop_converter_one,
    output logic             stop_converter_zero,
    output logic             stop_trace_debugger,
    output logic             stop_boundary_debug,
    output logic             stop_break_controller
);
    // every check below runs on mclk and rests during reset
    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ========================================
    // state
    typedef struct packed {
        msrc_pkg::msrc_state_t st;
        logic [7:0]            sys;
        logic [15:0]           st1;
        logic [15:0]           st2;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  err;
    } msrc_regs_t;

    msrc_regs_t          s_r;
    msrc_regs_t          s_nxt;
    msrc_pkg::msrc_sel_t sel;
    logic [15:0]         wmask;
    logic [15:0]         wd16;

    // ========================================
    // submodules
    msrc_decode u_dec (
        .paddr (paddr),
        .sel   (sel)
    );

    msrc_ram_gate u_gate (
        .ram_en        (s_r.sys[`MSRC_BIT_RAM_EN]),
        .cpu_ram_we    (cpu_ram_we),
        .ram_rdata     (ram_rdata),
        .ram_we        (ram_we),
        .cpu_ram_rdata (cpu_ram_rdata)
    );

    // ========================================
    // next state
    // byte strobes widened to a 16-bit lane mask
    always_comb begin
        wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wd16  = pwdata[15:0];
        s_nxt = s_r;
        s_nxt.ready = 1'b0;
        s_nxt.err   = 1'b0;
        case (s_r.st)
            msrc_pkg::MSRC_ST_IDLE: begin
                if (psel && !penable) begin
                    s_nxt.st    = msrc_pkg::MSRC_ST_ACC;
                    s_nxt.ready = 1'b1;
                    s_nxt.err   = (sel == msrc_pkg::MSRC_SEL_NONE);
                    // RL14 reserved reads zero
                    // RL15 zero bits
                    // RL10 ones forced
                    // RL13 single ones
                    case (sel)
                        msrc_pkg::MSRC_SEL_SYS: s_nxt.rdata =
                            {24'h000000, (s_r.sys & `MSRC_WM_SYSCTL)
                                         | `MSRC_ONE_SYSCTL};
                        msrc_pkg::MSRC_SEL_ST1: s_nxt.rdata =
                            {16'h0000, (s_r.st1 & `MSRC_WM_STBY1)
                                       | `MSRC_ONE_STBY1};
                        msrc_pkg::MSRC_SEL_ST2: s_nxt.rdata =
                            {16'h0000, (s_r.st2 & `MSRC_WM_STBY2)
                                       | `MSRC_ONE_STBY2};
                        default: s_nxt.rdata = 32'h00000000;
                    endcase
                end
            end
            msrc_pkg::MSRC_ST_ACC: begin
                s_nxt.st = msrc_pkg::MSRC_ST_IDLE;
                // RL17 write at completing edge
                if (psel && penable && pwrite) begin
                    // RL6 writable system bits
                    if (sel == msrc_pkg::MSRC_SEL_SYS && pstrb[0]) begin
                        s_nxt.sys = (pwdata[7:0] & `MSRC_WM_SYSCTL)
                                    | `MSRC_ONE_SYSCTL;
                    end
                    // RL7 standby bits
                    if (sel == msrc_pkg::MSRC_SEL_ST1) begin
                        s_nxt.st1 = (s_r.st1 & ~(wmask & `MSRC_WM_STBY1))
                                    | (wd16 & wmask & `MSRC_WM_STBY1);
                    end
                    if (sel == msrc_pkg::MSRC_SEL_ST2) begin
                        s_nxt.st2 = (s_r.st2 & ~(wmask & `MSRC_WM_STBY2))
                                    | (wd16 & wmask & `MSRC_WM_STBY2);
                    end
                end
            end
            default: s_nxt.st = msrc_pkg::MSRC_ST_IDLE;
        endcase
    end

    // ========================================
    // registers
    // RL2 enable resets on
    // RL1 trace reset held
    // RL9 first reset values
    // RL11 second reset ones
    // RL12 second reset zeros
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r.st    <= msrc_pkg::MSRC_ST_IDLE;
            s_r.sys   <= `MSRC_RST_SYSCTL;
            s_r.st1   <= `MSRC_RST_STBY1;
            s_r.st2   <= `MSRC_RST_STBY2;
            s_r.rdata <= 32'h00000000;
            s_r.ready <= 1'b0;
            s_r.err   <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================
    // outputs straight from flops
    always_comb begin
        prdata                      = s_r.rdata;
        pready                      = s_r.ready;
        pslverr                     = s_r.err;
        internal_ram_enable         = s_r.sys[`MSRC_BIT_RAM_EN];
        trace_debugger_soft_reset_n = s_r.sys[`MSRC_BIT_TRC_RSTN];
        stop_internal_ram           = s_r.st1[`MSRC_BIT_S_RAM];
        stop_internal_rom           = s_r.st1[`MSRC_BIT_S_ROM];
        // RL8 both bits driven separately
        stop_transfer_ctrl_hi       = s_r.st1[`MSRC_BIT_S_XFER_HI];
        stop_transfer_ctrl_lo       = s_r.st1[`MSRC_BIT_S_XFER_LO];
        stop_serial_four            = s_r.st1[`MSRC_BIT_S_SER4];
        stop_serial_three           = s_r.st1[`MSRC_BIT_S_SER3];
        stop_serial_two             = s_r.st1[`MSRC_BIT_S_SER2];
        stop_motor_timer            = s_r.st2[`MSRC_BIT_S_MOTOR];
        stop_pulse_timer            = s_r.st2[`MSRC_BIT_S_PULSE];
        stop_compare_timer          = s_r.st2[`MSRC_BIT_S_CMPT];
        stop_can_controller         = s_r.st2[`MSRC_BIT_S_CAN];
        stop_converter_two          = s_r.st2[`MSRC_BIT_S_CONV2];
        stop_converter_one          = s_r.st2[`MSRC_BIT_S_CONV1];
        stop_converter_zero         = s_r.st2[`MSRC_BIT_S_CONV0];
        stop_trace_debugger         = s_r.st2[`MSRC_BIT_S_TRACE];
        stop_boundary_debug         = s_r.st2[`MSRC_BIT_S_BOUND];
        stop_break_controller       = s_r.st2[`MSRC_BIT_S_BREAK];
    end

    // ========================================
    // checks
    // completed writes, one sequence per register and lane
    sequence sys_wr_s;
        psel && penable && pwrite && pready
            && (paddr == `MSRC_OFS_SYSCTL) && pstrb[0];
    endsequence
    sequence st1_lo_wr_s;
        psel && penable && pwrite && pready
            && (paddr == `MSRC_OFS_STBY1) && pstrb[0];
    endsequence
    sequence st1_hi_wr_s;
        psel && penable && pwrite && pready
            && (paddr == `MSRC_OFS_STBY1) && pstrb[1];
    endsequence
    sequence st2_lo_wr_s;
        psel && penable && pwrite && pready
            && (paddr == `MSRC_OFS_STBY2) && pstrb[0];
    endsequence
    sequence st2_hi_wr_s;
        psel && penable && pwrite && pready
            && (paddr == `MSRC_OFS_STBY2) && pstrb[1];
    endsequence

    // apb setup cycle and the ready pulse that answers it
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ready_pulse_s;
        pready ##1 !pready;
    endsequence

    // RL1 trace reset follows
    a_trace_rst_follow: assert property ( // RL1
        sys_wr_s |=> trace_debugger_soft_reset_n == $past(pwdata[1]))
        else $error("trace reset not following write");
    // RL2 ram enable follows
    a_ram_en_follow: assert property ( // RL2
        sys_wr_s |=> internal_ram_enable == $past(pwdata[0]))
        else $error("ram enable not following write");
    // RL3 disabled writes dropped
    a_ram_write_drop: assert property ( // RL3
        !internal_ram_enable |-> !ram_we)
        else $error("ram write passed while disabled");
    // RL3 disabled reads give filler
    a_ram_read_fill: assert property ( // RL3
        !internal_ram_enable |-> cpu_ram_rdata == 32'hFFFFFFFF)
        else $error("ram read passed while disabled");
    // RL2 enabled ram passes
    a_ram_pass: assert property ( // RL2
        internal_ram_enable |-> (ram_we == cpu_ram_we)
            && (cpu_ram_rdata == ram_rdata))
        else $error("ram access blocked while enabled");
    // RL6 system reserved bits
    a_sys_ones_read: assert property ( // RL6
        pready && (paddr == `MSRC_OFS_SYSCTL) && !pwrite
            |-> prdata[7:2] == 6'h30)
        else $error("system control reserved bits wrong");
    // RL6 unstrobed lane ignored
    a_sys_lane_keep: assert property ( // RL6
        psel && penable && pwrite && pready && !pstrb[0]
            && (paddr == `MSRC_OFS_SYSCTL) |=> $stable(s_r.sys))
        else $error("system control changed without strobe");
    // RL10 first standby ones
    a_stby1_ones: assert property ( // RL10
        pready && (paddr == `MSRC_OFS_STBY1) && !pwrite
            |-> (prdata[15:12] == 4'hF) && (prdata[1:0] == 2'h3))
        else $error("first standby reserved ones wrong");
    // RL14 first standby zeros
    a_stby1_zero: assert property ( // RL14
        pready && (paddr == `MSRC_OFS_STBY1) && !pwrite
            |-> prdata[7:5] == 3'h1)
        else $error("first standby bits 7 to 5 wrong");
    // RL15 second standby reserved
    a_stby2_zero: assert property ( // RL15
        pready && (paddr == `MSRC_OFS_STBY2) && !pwrite
            |-> {prdata[15], prdata[11:10], prdata[8:7], prdata[1]}
                == 6'h22)
        else $error("second standby reserved bits wrong");
    // RL14 upper half reads zero
    a_rd_upper_zero: assert property ( // RL14
        pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    // RL6 unmapped access refused
    a_unmapped_err: assert property ( // RL6
        psel && !penable && (sel == msrc_pkg::MSRC_SEL_NONE)
            |=> pslverr && (prdata == 32'h00000000))
        else $error("unmapped access not refused");
    // RL6 mapped access accepted
    a_mapped_ok: assert property ( // RL6
        psel && !penable && (sel != msrc_pkg::MSRC_SEL_NONE)
            |=> !pslverr)
        else $error("mapped access flagged as error");
    // RL9 ram standby follows
    a_ram_stby_follow: assert property ( // RL9
        st1_hi_wr_s |=> stop_internal_ram == $past(pwdata[11]))
        else $error("ram standby not following write");
    // RL9 rom standby follows
    a_rom_stby_follow: assert property ( // RL9
        st1_hi_wr_s |=> stop_internal_rom == $past(pwdata[10]))
        else $error("rom standby not following write");
    // RL9 transfer pair follows
    a_xfer_follow: assert property ( // RL9
        st1_hi_wr_s |=> {stop_transfer_ctrl_hi, stop_transfer_ctrl_lo}
            == $past(pwdata[9:8]))
        else $error("transfer standby not following write");
    // RL9 serial stops follow
    a_serial_follow: assert property ( // RL9
        st1_lo_wr_s |=> {stop_serial_four, stop_serial_three,
            stop_serial_two} == $past(pwdata[4:2]))
        else $error("serial standby not following write");
    // RL7 upper lane kept
    a_lane_keep: assert property ( // RL7
        psel && penable && pwrite && pready && !pstrb[1]
            && (paddr == `MSRC_OFS_STBY1) |=> $stable(s_r.st1[15:8]))
        else $error("first standby upper lane changed");
    // RL7 can standby follows
    a_stby2_follow: assert property ( // RL7
        st2_hi_wr_s |=> stop_can_controller == $past(pwdata[9]))
        else $error("can standby not following write");
    // RL11 timer stops follow
    a_timer_follow: assert property ( // RL11
        st2_hi_wr_s |=> {stop_motor_timer, stop_pulse_timer,
            stop_compare_timer} == $past(pwdata[14:12]))
        else $error("timer standby not following write");
    // RL11 converter stops follow
    a_conv_follow: assert property ( // RL11
        st2_lo_wr_s |=> {stop_converter_two, stop_converter_one,
            stop_converter_zero} == $past(pwdata[6:4]))
        else $error("converter standby not following write");
    // RL12 debug stops follow
    a_debug_follow: assert property ( // RL12
        st2_lo_wr_s |=> {stop_trace_debugger, stop_boundary_debug,
            stop_break_controller} == {$past(pwdata[3:2]), $past(pwdata[0])})
        else $error("debug standby not following write");
    // RL17 controls move only on writes
    a_ctrl_hold: assert property ( // RL17
        !(psel && penable && pwrite && pready)
            |=> $stable({s_r.sys, s_r.st1, s_r.st2}))
        else $error("control level changed without a write");
    // RL17 one ready pulse
    a_ready_one: assert property ( // RL17
        setup_s |=> ready_pulse_s)
        else $error("apb ready timing wrong");
endmodule // msrc_top

// [bench/msrc_periph_model.sv]
`timescale 1ns/10ps
// ==========================================
// on-chip ram seen from behind the gate
module msrc_periph_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // ram port
    input  wire logic        ram_we,
    output logic [31:0]      ram_rdata,
    output logic [7:0]       wr_cnt
);
    // counts writes that really reach the array
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) wr_cnt <= 8'h00;
        else if (ram_we) wr_cnt <= wr_cnt + 8'h01;
    end
    // read word moves with every accepted write
    assign ram_rdata = {4{wr_cnt}} ^ 32'hA5C30F96;
endmodule // msrc_periph_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
// ==========================================
// register and ram gate bench
module tb_top;
    logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, cpu_ram_we = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata, ram_rdata, cpu_ram_rdata;
    logic        pready, pslverr, ram_we;
    logic [7:0]  wr_cnt;
    logic [18:0] ctl;
    int          miscompares = 0, n_compared = 0, cyc = 0;
    logic [11:0] adr [3] = '{12'h000, 12'h004, 12'h008};
    logic [15:0] wm [3]  = '{16'h0003, 16'h0F1C, 16'h727D};
    logic [15:0] one [3] = '{16'h00C0, 16'hF023, 16'h8080};
    logic [15:0] v [3]   = '{16'h00C1, 16'hF03F, 16'hF0F0};
    msrc_top msrc_top_inst (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_ram_we(cpu_ram_we), .ram_rdata(ram_rdata), .ram_we(ram_we),
        .cpu_ram_rdata(cpu_ram_rdata), .internal_ram_enable(ctl[18]),
        .trace_debugger_soft_reset_n(ctl[17]), .stop_internal_ram(ctl[16]),
        .stop_internal_rom(ctl[15]), .stop_transfer_ctrl_hi(ctl[14]),
        .stop_transfer_ctrl_lo(ctl[13]), .stop_serial_four(ctl[12]),
        .stop_serial_three(ctl[11]), .stop_serial_two(ctl[10]),
        .stop_motor_timer(ctl[9]), .stop_pulse_timer(ctl[8]),
        .stop_compare_timer(ctl[7]), .stop_can_controller(ctl[6]),
        .stop_converter_two(ctl[5]), .stop_converter_one(ctl[4]),
        .stop_converter_zero(ctl[3]), .stop_trace_debugger(ctl[2]),
        .stop_boundary_debug(ctl[1]), .stop_break_controller(ctl[0]));
    msrc_periph_model msrc_periph_model_inst (.mclk(mclk), .rst(rst),
        .ram_we(ram_we), .ram_rdata(ram_rdata), .wr_cnt(wr_cnt));
    // clock and cycle ceiling
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // control levels follow the register bits
    function automatic logic [31:0] ctl_exp();
        return {13'h0000, v[0][0], v[0][1], v[1][11], v[1][10], v[1][9],
            v[1][8], v[1][4], v[1][3], v[1][2], v[2][14], v[2][13], v[2][12],
            v[2][9], v[2][6], v[2][5], v[2][4], v[2][3], v[2][2], v[2][0]};
    endfunction
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] rd,
        output logic er);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        forever begin
            @(posedge mclk);
            if (pready === 1'b1) break;
            n++;
            if (n > 50) begin
                miscompares++;
                test_done();
            end
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input int r, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, adr[r], d, s, rd, er);
        if (s[0]) v[r][7:0] = (d[7:0] & wm[r][7:0]) | one[r][7:0];
        if (s[1] && r > 0) v[r][15:8] = (d[15:8] & wm[r][15:8]) | one[r][15:8];
        @(negedge mclk);
        chk({13'h0000, ctl}, ctl_exp());
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
        input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h00000000, 4'h0, rd, er);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask
    task automatic rd_all();
        for (int r = 0; r < 3; r++) rdc(adr[r], {16'h0000, v[r]}, 1'b0);
    endtask
    // reset values and levels
    task automatic t_reset();
        rd_all();
        chk({13'h0000, ctl}, ctl_exp());
    endtask
    // walking one through every bit, then single byte lanes
    task automatic t_bits();
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < ((r == 0) ? 8 : 16); i++) begin
                wr(r, 32'h1 << i, 4'hF);
                rd_all();
            end
        end
        wr(1, 32'h0000FFFF, 4'h1);
        wr(1, 32'h0000FF00, 4'h2);
        rd_all();
        wr(1, 32'h0000F03F, 4'h3);
        wr(0, 32'h000000C3, 4'h1);
        wr(0, 32'h00000000, 4'h2);
        rd_all();
    endtask
    task automatic ram_try(input logic [7:0] cnt, input logic en);
        @(posedge mclk) cpu_ram_we <= 1'b1;
        @(negedge mclk);
        chk({31'h0, ram_we}, {31'h0, en});
        chk(cpu_ram_rdata, en ? ({4{cnt}} ^ 32'hA5C30F96) : 32'hFFFFFFFF);
        @(posedge mclk) cpu_ram_we <= 1'b0;
        @(negedge mclk);
        chk({24'h0, wr_cnt}, {24'h0, cnt + {7'h00, en}});
    endtask
    // ram gate enabled, disabled, enabled again
    task automatic t_ram();
        ram_try(wr_cnt, 1'b1);
        wr(0, 32'h000000C2, 4'h1);
        // no ram access right after clearing
        rdc(adr[0], 32'h000000C2, 1'b0);
        ram_try(wr_cnt, 1'b0);
        wr(0, 32'h000000C3, 4'h1);
        rdc(adr[0], 32'h000000C3, 1'b0);
        ram_try(wr_cnt, 1'b1);
    endtask
    // unmapped address gives an error and changes nothing
    task automatic t_unmapped();
        logic [31:0] rd;
        logic        er;
        rdc(12'h00C, 32'h00000000, 1'b1);
        apb(1'b1, 12'h00C, 32'h00000000, 4'hF, rd, er);
        chk({31'h0, er}, 32'h00000001);
        rd_all();
    endtask
    // reset again mid-run restores every default
    task automatic t_rerst();
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        v = '{16'h00C1, 16'hF03F, 16'hF0F0};
        t_reset();
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_bits();
        t_ram();
        t_unmapped();
        t_rerst();
        test_done();
    end
endmodule // tb_top
